/* hdl/atc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the timer control block.
// Included by the package file and by atc_timer; holds definitions only.
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

`define ATC_ADDR_W        4
`define ATC_OFS_CONTROL   4'h0
`define ATC_OFS_COUNT     4'h4
`define ATC_OFS_PERIOD    4'h8

`define ATC_BIT_ON        15
`define ATC_BIT_STOP_IDLE 13
`define ATC_BIT_WBLK      12
`define ATC_BIT_WPEND     11
`define ATC_BIT_GATE      7
`define ATC_BIT_PS_HI     5
`define ATC_BIT_PS_LO     4
`define ATC_BIT_SYNC      2
`define ATC_BIT_CS        1

`define ATC_CTRL_WMASK    32'h0000_B0B6
`define ATC_CTRL_RESET    32'h0000_0000
`define ATC_COUNT_RESET   16'h0000
`define ATC_PERIOD_RESET  16'hFFFF

`define ATC_PS_DIV1       8'h00
`define ATC_PS_DIV8       8'h07
`define ATC_PS_DIV64      8'h3F
`define ATC_PS_DIV256     8'hFF

`define ATC_XFER_CYCLES   2'h3

`endif

/* hdl/atc_pkg.sv */
// Types shared by the timer control block.
// Assumes atc_regs.svh is on the include path.
`include "atc_regs.svh"
package atc_pkg;
	typedef enum logic [1:0] {
		ATC_PS_1,
		ATC_PS_8,
		ATC_PS_64,
		ATC_PS_256
	} atc_prescale_e;

	typedef enum logic [1:0] {
		ATC_W_IDLE,
		ATC_W_XFER
	} atc_wstate_e;
endpackage

/* hdl/atc_edge_sync.sv */
// Two-flop synchroniser with a rising-edge pulse taken after the second flop.
// Assumes a single clock domain on clk and an asynchronous active-low reset.
`timescale 1ns/1ps
module atc_edge_sync (
	input  wire logic clk,      // System clock.
	input  wire logic reset_n,  // Asynchronous reset, active low.
	input  wire logic async_in, // Level from outside the clock domain.
	output logic      level_q,  // Synchronised level.
	output logic      rise_q    // One-cycle pulse on a rising edge.
);
	logic meta_q;
	logic last_q;

	// The first flop feeds only the second one.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q  <= 1'b0;
			level_q <= 1'b0;
			last_q  <= 1'b0;
			rise_q  <= 1'b0;
		end else begin
			meta_q  <= async_in;
			level_q <= meta_q;
			last_q  <= level_q;
			rise_q  <= level_q & ~last_q;
		end
	end
endmodule

/* hdl/atc_timer.sv */
// Type A timer control logic: enable, idle stop, prescaler, gating and count-write protection.
// Assumes a single 25 MHz sys_clk, a plain register port and raw external clock and gate pins.
//
// Operation
// - Timer counts only while enable bit set.
// - Stop in idle halts timer during idle.
// - Blocked mode drops count writes while pending.
// - Unblocked mode accepts back-to-back count writes.
// - Pending flag high during async count write.
// - Pending flag reads zero in synchronous mode.
// - External clock source ignores gate enable.
// - Internal clock source lets gate enable gating.
// - Prescaler divides by 1, 8, 64, 256.
// - Unimplemented control bits ignore writes, read zero.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "atc_regs.svh"
module atc_timer #(
	parameter int COUNT_W = 16 // Width of the count and period registers.
) (
	input  wire logic                   sys_clk,    // System clock, 25 MHz.
	input  wire logic                   reset_n,    // Asynchronous reset, active low.
	input  wire logic [`ATC_ADDR_W-1:0] addr,       // Register byte address.
	input  wire logic [31:0]            wdata,      // Write data.
	input  wire logic                   wr_en,      // Write strobe, one cycle.
	input  wire logic                   rd_en,      // Read strobe, one cycle.
	output logic      [31:0]            rdata_q,    // Read data, valid the cycle after rd_en.
	input  wire logic                   idle_mode,  // Device is in idle mode.
	input  wire logic                   ext_clk,    // External timer clock pin.
	input  wire logic                   gate_in,    // Gate pin for gated accumulation.
	output logic                        match_q     // One-cycle pulse when count wraps at period.
);
	logic [31:0]        ctrl_q;
	logic [COUNT_W-1:0] count_q;
	logic [COUNT_W-1:0] period_q;
	logic [7:0]         pre_cnt_q;
	logic               wpend_q;
	logic [1:0]         xfer_cnt_q;
	logic [COUNT_W-1:0] wbuf_q;
	atc_pkg::atc_wstate_e wstate_q;

	logic ext_level;
	logic ext_rise;
	logic gate_level;
	logic ext_raw_q;
	logic ext_raw_last_q;

	// External clock and gate pins pass two flops before any use.
	atc_edge_sync u_ext_sync (
		.clk      (sys_clk),
		.reset_n  (reset_n),
		.async_in (ext_clk),
		.level_q  (ext_level),
		.rise_q   (ext_rise)
	);

	atc_edge_sync u_gate_sync (
		.clk      (sys_clk),
		.reset_n  (reset_n),
		.async_in (gate_in),
		.level_q  (gate_level),
		.rise_q   ()
	);

	// Control field decode.
	wire        on_bit    = ctrl_q[`ATC_BIT_ON];
	wire        stop_idle_bit = ctrl_q[`ATC_BIT_STOP_IDLE];
	wire        wblk_bit  = ctrl_q[`ATC_BIT_WBLK];
	wire        gate_bit  = ctrl_q[`ATC_BIT_GATE];
	wire        sync_bit  = ctrl_q[`ATC_BIT_SYNC];
	wire        cs_bit    = ctrl_q[`ATC_BIT_CS];
	wire [1:0]  ps_field  = ctrl_q[`ATC_BIT_PS_HI:`ATC_BIT_PS_LO];
	wire        async_mode = cs_bit & ~sync_bit;

	// Register decode.
	wire sel_ctrl   = (addr == `ATC_OFS_CONTROL);
	wire sel_count  = (addr == `ATC_OFS_COUNT);
	wire sel_period = (addr == `ATC_OFS_PERIOD);
	wire wr_ctrl    = wr_en & sel_ctrl;
	wire wr_count   = wr_en & sel_count;
	wire wr_period  = wr_en & sel_period;

	wire count_wr_ok = wr_count & ~(wblk_bit & wpend_q & async_mode);

	// source and sync
	// An unsynchronised external clock is sampled raw after the synchroniser level for edge detection.
	wire ext_tick = sync_bit ? ext_rise : (ext_raw_q & ~ext_raw_last_q);
	wire src_tick = cs_bit ? ext_tick : 1'b1;

	wire run = on_bit & ~(stop_idle_bit & idle_mode);

	wire gated = gate_bit & ~cs_bit;

	wire gate_ok = ~gated | gate_level;

	wire [7:0] pre_limit = (ps_field == atc_pkg::ATC_PS_256) ? `ATC_PS_DIV256 :
	                       (ps_field == atc_pkg::ATC_PS_64)  ? `ATC_PS_DIV64  :
	                       (ps_field == atc_pkg::ATC_PS_8)   ? `ATC_PS_DIV8   : `ATC_PS_DIV1;
	wire       pre_step  = run & gate_ok & src_tick;
	wire       pre_done  = pre_step & (pre_cnt_q >= pre_limit);
	wire       at_period = (count_q == period_q);

	wire [31:0] ctrl_rd = (ctrl_q & `ATC_CTRL_WMASK) |
	                      ({31'h0000_0000, wpend_q & async_mode} << `ATC_BIT_WPEND);
	wire [31:0] rd_mux  = sel_ctrl   ? ctrl_rd :
	                      sel_count  ? {{(32-COUNT_W){1'b0}}, count_q} :
	                      sel_period ? {{(32-COUNT_W){1'b0}}, period_q} : 32'h0000_0000;

	// Raw second sample of the synchronised external level for the unsynchronised path.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_raw_q      <= 1'b0;
			ext_raw_last_q <= 1'b0;
		end else begin
			ext_raw_q      <= ext_level;
			ext_raw_last_q <= ext_raw_q;
		end
	end

	// Control and period registers; unimplemented bits are masked off.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q   <= `ATC_CTRL_RESET;
			period_q <= `ATC_PERIOD_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wdata & `ATC_CTRL_WMASK;
			end
			if (wr_period) begin
				period_q <= wdata[COUNT_W-1:0];
			end
		end
	end

	// Asynchronous count-write transfer; it takes a fixed number of cycles to land.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wstate_q   <= atc_pkg::ATC_W_IDLE;
			wpend_q    <= 1'b0;
			xfer_cnt_q <= 2'h0;
			wbuf_q     <= `ATC_COUNT_RESET;
		end else begin
			unique case (wstate_q)
				atc_pkg::ATC_W_IDLE: begin
					if (count_wr_ok && async_mode) begin
						wstate_q   <= atc_pkg::ATC_W_XFER;
						wpend_q    <= 1'b1;
						xfer_cnt_q <= `ATC_XFER_CYCLES;
						wbuf_q     <= wdata[COUNT_W-1:0];
					end
				end
				atc_pkg::ATC_W_XFER: begin
					// a new accepted write restarts the transfer
					if (count_wr_ok) begin
						xfer_cnt_q <= `ATC_XFER_CYCLES;
						wbuf_q     <= wdata[COUNT_W-1:0];
					end else if (xfer_cnt_q == 2'h1 || !async_mode) begin
						wstate_q <= atc_pkg::ATC_W_IDLE;
						wpend_q  <= 1'b0;
					end else begin
						xfer_cnt_q <= xfer_cnt_q - 2'h1;
					end
				end
				// The state word has two spare codes; an upset one falls back to idle.
				default: begin
					wstate_q <= atc_pkg::ATC_W_IDLE;
					wpend_q  <= 1'b0;
				end
			endcase
		end
	end

	wire xfer_land = (wstate_q == atc_pkg::ATC_W_XFER) && !count_wr_ok &&
	                 (xfer_cnt_q == 2'h1) && async_mode;

	// Prescaler and counter; a landing write overrides counting.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_cnt_q <= 8'h00;
			count_q   <= `ATC_COUNT_RESET;
			match_q   <= 1'b0;
		end else begin
			match_q <= 1'b0;
			if (!on_bit) begin
				pre_cnt_q <= 8'h00;
			end else if (pre_step) begin
				pre_cnt_q <= pre_done ? 8'h00 : pre_cnt_q + 8'h01;
			end
			if (count_wr_ok && !async_mode) begin
				count_q <= wdata[COUNT_W-1:0];
			end else if (xfer_land) begin
				count_q <= wbuf_q;
			end else if (pre_done) begin
				count_q <= at_period ? `ATC_COUNT_RESET : count_q + 1'b1;
				match_q <= at_period;
			end
		end
	end

	// Read data stand for one cycle after the read strobe.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rd_en ? rd_mux : 32'h0000_0000;
		end
	end
endmodule

/* tb/atc_timer_checker.sv */
// Checker for the register port of the timer control block.
// Bound into every atc_timer and sees only its ports.
`timescale 1ns/1ps
module atc_timer_checker (
	input wire logic        sys_clk, // Clock.
	input wire logic        reset_n, // Reset, active low.
	input wire logic [3:0]  addr,    // Address.
	input wire logic [31:0] wdata,   // Write data.
	input wire logic        wr_en,   // Write strobe.
	input wire logic        rd_en,   // Read strobe.
	input wire logic [31:0] rdata_q  // Read data.
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	chk_rd_quiet: assert property (!rd_en |=> rdata_q == 32'h0) else $error("stray read data");
	chk_unimpl_zero: assert property (rd_en && addr == 4'h0 |=> (rdata_q & ~32'h0000B8B6) == 32'h0)
		else $error("control reserved bit set");
	chk_pend_sync: assert property (rd_en && addr == 4'h0 |=> !(rdata_q[11] && (!rdata_q[1] || rdata_q[2])))
		else $error("pending flag in sync mode");
	chk_ctrl_write: assert property ((wr_en && addr == 4'h0) ##1 (rd_en && addr == 4'h0)
		|=> (rdata_q & 32'hB0B6) == ($past(wdata, 2) & 32'hB0B6)) else $error("control readback wrong");
	chk_pend_rise: assert property ((wr_en && addr == 4'h0 && wdata[2:1] == 2'b01) ##1 (wr_en && addr == 4'h4)
		##1 (rd_en && addr == 4'h0) |=> rdata_q[11]) else $error("pending flag missing");
	chk_unmapped_read: assert property (rd_en && !(addr inside {4'h0, 4'h4, 4'h8}) |=> rdata_q == 32'h0)
		else $error("unmapped read not zero");
	chk_cnt_upper: assert property (rd_en && (addr == 4'h4 || addr == 4'h8) |=> rdata_q[31:16] == 16'h0)
		else $error("count upper half set");
	chk_rst_quiet: assert property ($rose(reset_n) |-> rdata_q == 32'h0) else $error("read data after reset");
endmodule
bind atc_timer atc_timer_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q));

/* tb/async_timer_control_test.sv */
// Self-checking bench of the timer control block.
// Drives every port of atc_timer itself; no partner model.
`timescale 1ns/1ps
module async_timer_control_test;
	logic        sys_clk = 0, reset_n = 0, wr_en = 0, rd_en = 0, idle_mode = 0, ext_clk = 0, gate_in = 0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0, d, r, seed = 32'hF;
	wire  [31:0] rdata_q;
	wire         match_q;
	int          fail_count = 0, n_compared = 0, cyc = 0, k, ev, m0, n_match = 0;
	// Behavioural model of the control and period registers, kept from the rules.
	int          m_ctrl = 0, m_period = 32'hFFFF;
	int          divs[4] = '{1, 8, 64, 256};
	atc_timer dut (.sys_clk(sys_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata_q(rdata_q), .idle_mode(idle_mode), .ext_clk(ext_clk), .gate_in(gate_in),
		.match_q(match_q));
	// Counts the wrap pulses, sampled where they stand.
	always @(posedge sys_clk) begin
		if (match_q === 1'b1)
			n_match <= n_match + 1;
	end
	// Clock and a cycle ceiling that cuts a hang short.
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string s, input int lo, input int hi, input logic [31:0] v);
		n_compared++;
		if ($isunknown(v) || v < lo || v > hi) begin
			$display("[ERR] %s expected %0h..%0h seen %0h", s, lo, hi, v);
			fail_count++;
		end
	endtask
	// The write task leaves its strobe up until the next task's edge lowers it, unless it clears a set enable bit; the read task lowers its own.
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		rd_en <= 1'b0;
		if (a == 4'h0 && m_ctrl[15] && !v[15]) begin
			@(posedge sys_clk);
			wr_en <= 1'b0;
		end
		if (a == 4'h0)
			m_ctrl = v & 32'hB0B6;
		if (a == 4'h8)
			m_period = v & 32'hFFFF;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		wr_en <= 1'b0;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 d = rdata_q;
	endtask
	task automatic wt(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			wr_en <= 1'b0;
			rd_en <= 1'b0;
		end
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Main sequence.
	initial begin
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (k = 0; k < 16; k += 4) begin
			rd(k[3:0]);
			ev = (k == 8) ? m_period : 0;
			chk("reset", ev, ev, d);
		end
		repeat (8) begin
			r = xs();
			wr(4'h0, r);
			rd(4'h0);
			chk("control", m_ctrl, m_ctrl, d);
			wr(4'h8, r >> 12);
			rd(4'h8);
			chk("period", m_period, m_period, d);
		end
		wr(4'h8, 32'h0000_FFFF);
		$display("test registers done");
		for (k = 0; k < 4; k++) begin
			wr(4'h0, 32'h0);
			wr(4'h4, 32'h0);
			wr(4'h0, 32'h8000 | (k << 4));
			wt(40 * divs[k]);
			rd(4'h4);
			chk("prescale", 37, 42, d);
		end
		wr(4'h0, 32'h0);
		wt(2);
		wr(4'h4, 32'h0123);
		wt(50);
		rd(4'h4);
		chk("hold", 32'h123, 32'h123, d);
		wr(4'h4, 32'h0);
		wr(4'h8, 32'h0000_0004);
		wr(4'h0, 32'h8000);
		m0 = n_match;
		wt(50);
		chk("match", m0 + 8, m0 + 10, n_match);
		wr(4'h0, 32'h0);
		wr(4'h8, 32'h0000_FFFF);
		$display("test prescale done");
		wr(4'h4, 32'h0);
		idle_mode <= 1'b1;
		wr(4'h0, 32'hA000);
		wt(40);
		rd(4'h4);
		chk("idle stop", 0, 0, d);
		wr(4'h0, 32'h8000);
		wt(40);
		rd(4'h4);
		chk("idle run", 38, 44, d);
		wr(4'h0, 32'h0);
		idle_mode <= 1'b0;
		wr(4'h4, 32'h0);
		wr(4'h0, 32'h8080);
		wt(40);
		rd(4'h4);
		chk("gate low", 0, 0, d);
		wt(1);
		gate_in <= 1'b1;
		wt(39);
		rd(4'h4);
		chk("gate high", 35, 42, d);
		wt(1);
		gate_in <= 1'b0;
		// Ten external rising edges, first on the raw path and then on the synchronised one.
		for (k = 0; k < 2; k++) begin
			wr(4'h0, 32'h0);
			wr(4'h4, 32'h0);
			wr(4'h0, 32'h8082 | (k << 2));
			repeat (20) begin
				wt(4);
				ext_clk <= ~ext_clk;
			end
			wt(8);
			rd(4'h4);
			chk("external", 10, 10, d);
		end
		$display("test idle gate done");
		wr(4'h0, 32'h1002);
		wr(4'h4, 32'h1111);
		wr(4'h4, 32'h2222);
		wt(6);
		rd(4'h4);
		chk("blocked", 32'h1111, 32'h1111, d);
		rd(4'h0);
		chk("done flag", m_ctrl, m_ctrl, d);
		wr(4'h0, 32'h0002);
		wr(4'h4, 32'h3333);
		rd(4'h0);
		chk("busy flag", m_ctrl | 32'h0800, m_ctrl | 32'h0800, d);
		wr(4'h4, 32'h4444);
		wt(6);
		rd(4'h4);
		chk("unblocked", 32'h4444, 32'h4444, d);
		wr(4'h0, 32'h0006);
		wr(4'h4, 32'h5555);
		rd(4'h0);
		chk("sync flag", m_ctrl, m_ctrl, d);
		rd(4'h4);
		chk("sync load", 32'h5555, 32'h5555, d);
		$display("test writes done");
		complete_run();
	end
endmodule
